/* design/pxc_consts.vh */
`ifndef PXC_CONSTS_VH
`define PXC_CONSTS_VH

// management register numbers
`define PXC_REG_CTRL          5'h00
`define PXC_REG_FC_CNT        5'h14
`define PXC_REG_DROP_CNT      5'h15
`define PXC_REG_TENB          5'h16
`define PXC_REG_MAC_CFG       5'h17
`define PXC_REG_DRV_CFG       5'h18

// field positions
`define PXC_CTRL_SOFT_RST     15
`define PXC_TENB_FORCE_LINK   15
`define PXC_TENB_JABBER_DIS   14
`define PXC_TENB_ECHO_DIS     13
`define PXC_TENB_SQE_DIS      12
`define PXC_TENB_SQUELCH_HI   11
`define PXC_TENB_SQUELCH_LO   10
`define PXC_TENB_STICKY_EN    9
`define PXC_TENB_EOF_ERR      8
`define PXC_TENB_DISC         7
`define PXC_TENB_LINK         6
`define PXC_TENB_BCAST        0
`define PXC_MAC_RXCLK_SRC     13
`define PXC_MAC_IF_HI         12
`define PXC_MAC_IF_LO         11
`define PXC_MAC_FAR_LOOP      3
`define PXC_DRV_EDGE_HI       15
`define PXC_DRV_EDGE_LO       13

// reset values and counter ceiling
`define PXC_RST_FORCE_LINK    1'b0
`define PXC_RST_JABBER_DIS    1'b0
`define PXC_RST_ECHO_DIS      1'b1
`define PXC_RST_SQE_DIS       1'b1
`define PXC_RST_SQUELCH       2'b00
`define PXC_RST_STICKY_EN     1'b1
`define PXC_RST_BCAST         1'b0
`define PXC_RST_RXCLK_SRC     1'b0
`define PXC_RST_MAC_IF        2'b10
`define PXC_RST_FAR_LOOP      1'b0
`define PXC_RST_EDGE          3'b000
`define PXC_CNT_MAX           8'hFF

// encodings
`define PXC_SQUELCH_RSVD      2'b11
`define PXC_MAC_IF_RMII       2'b01
`define PXC_MAC_IF_RSVD       2'b11
`define PXC_OP_READ           2'b10
`define PXC_OP_WRITE          2'b01

// serial frame lengths, in management clock periods
`define PXC_PRE_ONES          6'd32
`define PXC_HDR_LAST          4'd12
`define PXC_DATA_BITS         5'd16
`define PXC_DATA_LAST         5'd15

`endif

/* design/pxc_ext_regs.v */
`timescale 1ns/10ps
`include "pxc_consts.vh"
// How it works
// - False carrier events counted in low byte of register 20; upper byte zero.
// - Copper link drops counted in low byte of register 21.
// - Counters saturate at 255, clear when read, reset to zero.
// - Force-link bit bypasses integrity test and reports link pass.
// - Bit 22.14 disables jabber detect; sticky, resets to zero.
// - Bit 22.13 disables transmit echo; sticky, resets to one.
// - Bit 22.12 disables SQE heartbeat; sticky, resets to one.
// - Squelch field selects normal, low or high level; code 11 reserved.
// - Sticky enable set keeps sticky bits over soft reset; clear restores defaults.
// - Sticky enable itself keeps its value on every soft reset.
// - End-of-frame error latched into a bit cleared by reading.
// - 10BASE-T disconnect latched into a bit cleared by reading.
// - Live 10BASE-T link state readable, resets to zero.
// - Broadcast bit makes every write apply regardless of PHY address.
// - Reads answered only when PHY address matches.
// - Receive clock follows recovered clock or reference clock; ignored in RMII.
// - MAC field selects MII, RMII, RGMII; resets to RGMII; 11 reserved.
// - New interface and clock selections apply at soft reset, or at once while low_power_hold_mode is high; reads show active.
// - Three-bit sticky edge-rate field, resets to 000.
module pxc_ext_regs (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       mdc,
    input  wire       mdio_in,
    output reg        mdio_out,
    output reg        mdio_oe,
    input  wire [4:0] phy_addr,
    input  wire       low_power_hold_mode,
    input  wire       false_carrier_evt,
    input  wire       link_drop_evt,
    input  wire       eof_err_evt,
    input  wire       tenb_disc_evt,
    input  wire       tenb_link_up,
    output reg        soft_reset,
    output reg        link_pass,
    output reg        jabber_dis,
    output reg        echo_dis,
    output reg        sqe_dis,
    output reg  [1:0] squelch_sel,
    output reg  [1:0] mac_if_sel,
    output reg        rx_clk_ref_sel,
    output reg        far_end_loopback,
    output reg  [2:0] edge_rate
);
    localparam [4:0] ST_PRE = 5'b00001;
    localparam [4:0] ST_HDR = 5'b00010;
    localparam [4:0] ST_TA  = 5'b00100;
    localparam [4:0] ST_WR  = 5'b01000;
    localparam [4:0] ST_RD  = 5'b10000;

    wire [7:0] sync_out;
    wire       mdc_s;
    wire       mdio_s;
    wire [4:0] addr_s;
    wire       hold_s;
    reg        mdc_d;
    wire       mdc_rise;

    pxc_sync2 #(.W(8)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     ({low_power_hold_mode, phy_addr, mdio_in, mdc}),
        .dout    (sync_out)
    );
    assign mdc_s    = sync_out[0];
    assign mdio_s   = sync_out[1];
    assign addr_s   = sync_out[6:2];
    assign hold_s   = sync_out[7];
    assign mdc_rise = mdc_s & ~mdc_d;

    // control and status state
    reg        force_link;
    reg        sticky_rst_en;
    reg        bcast_wr;
    reg        rx_clk_pend;
    reg [1:0]  mac_if_pend;
    reg        rx_clk_act;
    reg        eof_err;
    reg        tenb_disc;

    // serial frame engine
    reg [4:0]  state;
    reg [5:0]  ones;
    reg [4:0]  cnt;
    reg [15:0] sh;
    reg        is_read;
    reg [4:0]  reg_sel;
    reg        wr_en;
    reg [4:0]  wr_reg;
    reg [15:0] wr_data;
    reg        rd_clr;
    reg [4:0]  rd_reg;
    reg [15:0] rd_val;
    wire [12:0] hdr;
    wire       addr_ok;

    wire [7:0] fc_cnt;
    wire [7:0] drop_cnt;

    assign hdr     = {sh[11:0], mdio_s};
    assign addr_ok = (hdr[9:5] == addr_s);

    pxc_sat_cnt u_fc_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (false_carrier_evt),
        .clr     (rd_clr && rd_reg == `PXC_REG_FC_CNT),
        .cnt     (fc_cnt)
    );

    pxc_sat_cnt u_drop_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .inc     (link_drop_evt),
        .clr     (rd_clr && rd_reg == `PXC_REG_DROP_CNT),
        .cnt     (drop_cnt)
    );

    // read data mux
    always @* begin
        case (reg_sel)
            `PXC_REG_FC_CNT:   rd_val = {8'h00, fc_cnt};
            `PXC_REG_DROP_CNT: rd_val = {8'h00, drop_cnt};
            `PXC_REG_TENB:     rd_val = {force_link, jabber_dis, echo_dis,
                                         sqe_dis, squelch_sel, sticky_rst_en,
                                         eof_err, tenb_disc, link_pass,
                                         5'h00, bcast_wr};
            `PXC_REG_MAC_CFG:  rd_val = {2'b00, rx_clk_act, mac_if_sel,
                                         7'h00, far_end_loopback,
                                         3'b000};
            `PXC_REG_DRV_CFG:  rd_val = {edge_rate, 13'h0000};
            default:           rd_val = 16'h0000;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mdc_d    <= 1'b0;
            state    <= ST_PRE;
            ones     <= 6'd0;
            cnt      <= 5'd0;
            sh       <= 16'h0000;
            is_read  <= 1'b0;
            reg_sel  <= 5'd0;
            wr_en    <= 1'b0;
            wr_reg   <= 5'd0;
            wr_data  <= 16'h0000;
            rd_clr   <= 1'b0;
            rd_reg   <= 5'd0;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end else begin
            mdc_d  <= mdc_s;
            wr_en  <= 1'b0;
            rd_clr <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    ST_PRE: begin
                        if (mdio_s) begin
                            if (ones != `PXC_PRE_ONES)
                                ones <= ones + 6'd1;
                        end else begin
                            ones <= 6'd0;
                            if (ones == `PXC_PRE_ONES) begin
                                state <= ST_HDR;
                                cnt   <= 5'd0;
                            end
                        end
                    end
                    ST_HDR: begin
                        sh  <= {sh[14:0], mdio_s};
                        cnt <= cnt + 5'd1;
                        if (cnt[3:0] == `PXC_HDR_LAST) begin
                            reg_sel <= hdr[4:0];
                            cnt     <= 5'd0;
                            is_read <= (hdr[11:10] == `PXC_OP_READ);
                            if (!hdr[12]) begin
                                state <= ST_PRE;
                            end else if (hdr[11:10] == `PXC_OP_READ &&
                                         addr_ok) begin
                                state <= ST_TA;
                            end else if (hdr[11:10] == `PXC_OP_WRITE &&
                                         (addr_ok || bcast_wr)) begin
                                state <= ST_TA;
                            end else begin
                                state <= ST_PRE;
                            end
                        end
                    end
                    ST_TA: begin
                        if (is_read) begin
                            mdio_oe  <= 1'b1;
                            mdio_out <= 1'b0;
                            sh       <= rd_val;
                            rd_clr   <= 1'b1;
                            rd_reg   <= reg_sel;
                            state    <= ST_RD;
                        end else if (cnt[0]) begin
                            cnt   <= 5'd0;
                            state <= ST_WR;
                        end else begin
                            cnt <= 5'd1;
                        end
                    end
                    ST_WR: begin
                        sh  <= {sh[14:0], mdio_s};
                        cnt <= cnt + 5'd1;
                        if (cnt == `PXC_DATA_LAST) begin
                            wr_en   <= 1'b1;
                            wr_reg  <= reg_sel;
                            wr_data <= {sh[14:0], mdio_s};
                            state   <= ST_PRE;
                        end
                    end
                    ST_RD: begin
                        if (cnt == `PXC_DATA_BITS) begin
                            mdio_oe  <= 1'b0;
                            mdio_out <= 1'b0;
                            state    <= ST_PRE;
                        end else begin
                            mdio_out <= sh[15];
                            sh       <= {sh[14:0], 1'b0};
                            cnt      <= cnt + 5'd1;
                        end
                    end
                    default: state <= ST_PRE;
                endcase
            end
        end
    end

    // configuration bits
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset       <= 1'b0;
            force_link       <= `PXC_RST_FORCE_LINK;
            jabber_dis       <= `PXC_RST_JABBER_DIS;
            echo_dis         <= `PXC_RST_ECHO_DIS;
            sqe_dis          <= `PXC_RST_SQE_DIS;
            squelch_sel      <= `PXC_RST_SQUELCH;
            sticky_rst_en    <= `PXC_RST_STICKY_EN;
            bcast_wr         <= `PXC_RST_BCAST;
            rx_clk_pend      <= `PXC_RST_RXCLK_SRC;
            mac_if_pend      <= `PXC_RST_MAC_IF;
            rx_clk_act       <= `PXC_RST_RXCLK_SRC;
            mac_if_sel       <= `PXC_RST_MAC_IF;
            far_end_loopback <= `PXC_RST_FAR_LOOP;
            edge_rate        <= `PXC_RST_EDGE;
            rx_clk_ref_sel   <= 1'b0;
        end else begin
            soft_reset <= wr_en && wr_reg == `PXC_REG_CTRL &&
                          wr_data[`PXC_CTRL_SOFT_RST];
            // no effect of the clock source in RMII
            rx_clk_ref_sel <= rx_clk_act &&
                              mac_if_sel != `PXC_MAC_IF_RMII;
            if (soft_reset) begin
                // sticky enable is never touched here
                if (!sticky_rst_en) begin
                    force_link  <= `PXC_RST_FORCE_LINK;
                    jabber_dis  <= `PXC_RST_JABBER_DIS;
                    echo_dis    <= `PXC_RST_ECHO_DIS;
                    sqe_dis     <= `PXC_RST_SQE_DIS;
                    squelch_sel <= `PXC_RST_SQUELCH;
                    bcast_wr    <= `PXC_RST_BCAST;
                    edge_rate   <= `PXC_RST_EDGE;
                end
                mac_if_sel       <= mac_if_pend;
                rx_clk_act       <= rx_clk_pend;
                far_end_loopback <= `PXC_RST_FAR_LOOP;
            end else begin
                if (hold_s) begin
                    mac_if_sel <= mac_if_pend;
                    rx_clk_act <= rx_clk_pend;
                end
                if (wr_en && wr_reg == `PXC_REG_TENB) begin
                    force_link    <= wr_data[`PXC_TENB_FORCE_LINK];
                    jabber_dis    <= wr_data[`PXC_TENB_JABBER_DIS];
                    echo_dis      <= wr_data[`PXC_TENB_ECHO_DIS];
                    sqe_dis       <= wr_data[`PXC_TENB_SQE_DIS];
                    sticky_rst_en <= wr_data[`PXC_TENB_STICKY_EN];
                    bcast_wr      <= wr_data[`PXC_TENB_BCAST];
                    if (wr_data[`PXC_TENB_SQUELCH_HI:`PXC_TENB_SQUELCH_LO]
                        != `PXC_SQUELCH_RSVD)
                        squelch_sel <= wr_data[`PXC_TENB_SQUELCH_HI:
                                               `PXC_TENB_SQUELCH_LO];
                end
                if (wr_en && wr_reg == `PXC_REG_MAC_CFG) begin
                    rx_clk_pend      <= wr_data[`PXC_MAC_RXCLK_SRC];
                    far_end_loopback <= wr_data[`PXC_MAC_FAR_LOOP];
                    if (wr_data[`PXC_MAC_IF_HI:`PXC_MAC_IF_LO]
                        != `PXC_MAC_IF_RSVD)
                        mac_if_pend <= wr_data[`PXC_MAC_IF_HI:
                                               `PXC_MAC_IF_LO];
                end
                if (wr_en && wr_reg == `PXC_REG_DRV_CFG)
                    edge_rate <= wr_data[`PXC_DRV_EDGE_HI:
                                         `PXC_DRV_EDGE_LO];
            end
        end
    end

    // latched status, set wins over clear on read
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            eof_err   <= 1'b0;
            tenb_disc <= 1'b0;
            link_pass <= 1'b0;
        end else begin
            eof_err   <= eof_err_evt | (eof_err &
                         ~(rd_clr && rd_reg == `PXC_REG_TENB));
            tenb_disc <= tenb_disc_evt | (tenb_disc &
                         ~(rd_clr && rd_reg == `PXC_REG_TENB));
            link_pass <= force_link | tenb_link_up;
        end
    end
endmodule // pxc_ext_regs

/* design/pxc_sat_cnt.v */
`timescale 1ns/10ps
`include "pxc_consts.vh"
module pxc_sat_cnt (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       inc,
    input  wire       clr,
    output reg  [7:0] cnt
);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (clr) begin
            // an event in the read cycle is kept
            cnt <= inc ? 8'h01 : 8'h00;
        end else if (inc && cnt != `PXC_CNT_MAX) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // pxc_sat_cnt

/* design/pxc_sync2.v */
`timescale 1ns/10ps
module pxc_sync2 #(
    parameter W = 1
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // pxc_sync2

/* dv/phy_extended_ctrl_status_regs_tb.sv */
`timescale 1ns/10ps
module phy_extended_ctrl_status_regs_tb;
    logic        clk_sys, rst_n, hold, link_up, mdio_out, mdio_oe, mdc;
    logic        mdio_drv, mdio_drv_en, soft_reset, link_pass, far_lb;
    logic        jabber_dis, echo_dis, sqe_dis, rx_clk_ref_sel;
    logic [1:0]  squelch_sel, mac_if_sel;
    logic [2:0]  edge_rate;
    logic [3:0]  evt;
    logic [4:0]  my_phy;
    logic [15:0] rd, sh22, d;
    logic [31:0] rng;
    int          err_total = 0;
    int          total_checks = 0;
    int          n;
    // released line floats up through the pull-up
    wire         mdio_pin = mdio_oe ? mdio_out : mdio_drv_en ? mdio_drv : 1'b1;
    wire [5:0]   ctl = {link_pass, jabber_dis, echo_dis, sqe_dis, squelch_sel};
    pxc_host_model host (.clk_sys(clk_sys), .mdio_pin(mdio_pin), .mdc(mdc),
        .mdio_drv(mdio_drv), .mdio_drv_en(mdio_drv_en));
    pxc_ext_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .mdc(mdc),
        .mdio_in(mdio_pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .phy_addr(my_phy), .low_power_hold_mode(hold),
        .false_carrier_evt(evt[0]), .link_drop_evt(evt[1]),
        .eof_err_evt(evt[2]), .tenb_disc_evt(evt[3]),
        .tenb_link_up(link_up), .soft_reset(soft_reset),
        .link_pass(link_pass), .jabber_dis(jabber_dis), .echo_dis(echo_dis),
        .sqe_dis(sqe_dis), .squelch_sel(squelch_sel),
        .mac_if_sel(mac_if_sel), .rx_clk_ref_sel(rx_clk_ref_sel),
        .far_end_loopback(far_lb), .edge_rate(edge_rate));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // writable part of the 10BASE-T register, reserved squelch refused
    function automatic logic [15:0] w22(input logic [15:0] o, v);
        w22 = v & 16'hFE01;
        if (v[11:10] == 2'b11)
            w22[11:10] = o[11:10];
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [1:0] op, input logic [4:0] p,
        input logic [4:0] ra, input logic [15:0] v);
        rng = xs(rng);
        host.half = 5 + rng[1:0];
        host.frame(op, p, ra, v, rd);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] v);
        xfer(2'b01, my_phy, ra, v);
    endtask
    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
        xfer(2'b10, my_phy, ra, 16'h0000);
        chk(rd, exp);
    endtask
    task automatic pulse(input int k, input int c);
        repeat (c) begin
            @(posedge clk_sys);
            #1 evt[k] = 1'b1;
            @(posedge clk_sys);
            #1 evt[k] = 1'b0;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        hold = 1'b0;
        link_up = 1'b0;
        evt = 4'h0;
        rng = xs(32'd76169);
        my_phy = rng[4:0];
        sh22 = 16'h3200;
        repeat (16) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(ctl, 6'h0C);
        rdc(5'h16, 16'h3200);
        rdc(5'h17, 16'h1000);
        rdc(5'h18, 16'h0000);
        $display("test reset done");
        rng = xs(rng);
        n = 1 + rng[5:0];
        pulse(0, n);
        pulse(1, 260);
        rdc(5'h14, n[15:0]);
        rdc(5'h14, 16'h0000);
        rdc(5'h15, 16'h00FF);
        rdc(5'h1F, 16'h0000);
        $display("test counters done");
        pulse(2, 1);
        pulse(3, 1);
        link_up = 1'b1;
        rdc(5'h16, 16'h33C0);
        rdc(5'h16, 16'h3240);
        link_up = 1'b0;
        $display("test status done");
        d = 16'hFFFE;
        repeat (6) begin
            sh22 = w22(sh22, d);
            wr(5'h16, d);
            rdc(5'h16, sh22 | {9'h0, sh22[15], 6'h0});
            chk(ctl, sh22[15:10]);
            rng = xs(rng);
            d = (rng[15:0] | 16'h0200) & 16'hFFFE;
        end
        for (int c = 0; c < 8; c++) begin
            wr(5'h18, {c[2:0], 13'h1FFF});
            rdc(5'h18, {c[2:0], 13'h0000});
            chk(edge_rate, c[2:0]);
        end
        $display("test controls done");
        wr(5'h00, 16'h8000);
        rdc(5'h16, sh22 | {9'h0, sh22[15], 6'h0});
        chk(edge_rate, 3'h7);
        sh22 = sh22 & 16'hFDFF;
        wr(5'h16, sh22);
        wr(5'h00, 16'h8000);
        rdc(5'h16, 16'h3000);
        chk(edge_rate, 3'h0);
        wr(5'h16, 16'h3200);
        $display("test sticky done");
        wr(5'h17, 16'h2008);
        rdc(5'h17, 16'h1008);
        chk({mac_if_sel, rx_clk_ref_sel, far_lb}, 4'h9);
        wr(5'h00, 16'h8000);
        rdc(5'h17, 16'h2000);
        chk({mac_if_sel, rx_clk_ref_sel, far_lb}, 4'h2);
        wr(5'h17, 16'h2800);
        wr(5'h00, 16'h8000);
        rdc(5'h17, 16'h2800);
        chk({mac_if_sel, rx_clk_ref_sel}, 3'h2);
        hold = 1'b1;
        wr(5'h17, 16'h0000);
        chk({mac_if_sel, rx_clk_ref_sel}, 3'h0);
        wr(5'h17, 16'h3800);
        chk({mac_if_sel, rx_clk_ref_sel}, 3'h1);
        hold = 1'b0;
        $display("test interface done");
        xfer(2'b01, my_phy ^ 5'h01, 5'h16, 16'h7200);
        chk(jabber_dis, 1'b0);
        wr(5'h16, 16'h3201);
        xfer(2'b01, my_phy ^ 5'h01, 5'h16, 16'h7201);
        chk(jabber_dis, 1'b1);
        xfer(2'b10, my_phy ^ 5'h01, 5'h16, 16'h0000);
        chk(rd, 16'hFFFF);
        rdc(5'h16, 16'h7201);
        wr(5'h16, 16'h3200);
        xfer(2'b01, my_phy ^ 5'h01, 5'h16, 16'h7200);
        chk(jabber_dis, 1'b0);
        $display("test broadcast done");
        tally_and_finish();
    end
endmodule // phy_extended_ctrl_status_regs_tb

/* dv/pxc_checker.sv */
`timescale 1ns/10ps
module pxc_checker (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       mdc,
    input wire logic       mdio_out,
    input wire logic       mdio_oe,
    input wire logic       low_power_hold_mode,
    input wire logic       tenb_link_up,
    input wire logic       soft_reset,
    input wire logic       link_pass,
    input wire logic [1:0] squelch_sel,
    input wire logic [1:0] mac_if_sel,
    input wire logic       rx_clk_ref_sel
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic       mdc_q;
    logic [3:0] mdc_age;
    // cycles since the last management clock rise, saturating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mdc_q   <= 1'b0;
            mdc_age <= 4'hF;
        end else begin
            mdc_q <= mdc;
            if (mdc && !mdc_q)
                mdc_age <= 4'h0;
            else if (mdc_age != 4'hF)
                mdc_age <= mdc_age + 4'h1;
        end
    end
    AST_LINK_PASS: assert property (
        tenb_link_up [*2] |-> link_pass)
        else $error("link pass low while link up");
    AST_SRST_PULSE: assert property (
        soft_reset |=> !soft_reset)
        else $error("soft reset longer than one cycle");
    AST_SRST_CAUSE: assert property (
        soft_reset |-> mdc_age inside {[2:9]})
        else $error("soft reset not tied to a management clock rise");
    AST_READ_TURN: assert property (
        $rose(mdio_oe) |-> !mdio_out && mdc_age inside {[1:9]})
        else $error("read answer starts badly");
    AST_SQUELCH_CODE: assert property (
        squelch_sel != 2'b11)
        else $error("reserved squelch code active");
    AST_MAC_CODE: assert property (
        mac_if_sel != 2'b11)
        else $error("reserved interface code active");
    AST_RMII_CLK: assert property (
        (mac_if_sel == 2'b01) [*2] |-> !rx_clk_ref_sel)
        else $error("reference receive clock in reduced mode");
    AST_MODE_APPLY: assert property (
        !$stable({mac_if_sel, rx_clk_ref_sel}) |-> low_power_hold_mode
        || soft_reset || $past(soft_reset) || $past(soft_reset, 2)
        || $past(soft_reset, 3))
        else $error("mode changed without soft reset or hold");
    COV_SRST: cover property (soft_reset);
    COV_READ: cover property ($rose(mdio_oe));
    COV_RMII: cover property (mac_if_sel == 2'b01);
endmodule // pxc_checker

bind pxc_ext_regs pxc_checker u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .low_power_hold_mode(low_power_hold_mode),
    .tenb_link_up(tenb_link_up), .soft_reset(soft_reset),
    .link_pass(link_pass), .squelch_sel(squelch_sel),
    .mac_if_sel(mac_if_sel), .rx_clk_ref_sel(rx_clk_ref_sel));

/* dv/pxc_host_model.sv */
`timescale 1ns/10ps
module pxc_host_model (
    input  wire logic clk_sys,
    input  wire logic mdio_pin,
    output logic      mdc,
    output logic      mdio_drv,
    output logic      mdio_drv_en
);
    int half = 6;
    initial begin
        mdc = 1'b0;
        mdio_drv = 1'b1;
        mdio_drv_en = 1'b0;
    end
    // level set in the low phase, pin sampled just before the rise
    task automatic cyc(input logic en, input logic b, output logic s);
        repeat (half) @(posedge clk_sys);
        #1 mdc = 1'b0;
        mdio_drv_en = en;
        mdio_drv = b;
        repeat (half) @(posedge clk_sys);
        #1 s = mdio_pin;
        mdc = 1'b1;
    endtask
    // every frame carries its own preamble; clock stands high after it
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [13:0] hdr;
        logic        w;
        logic        s;
        hdr = {2'b01, op, phy, ra};
        w = (op == 2'b01);
        for (int i = 0; i < 32; i++)
            cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--)
            cyc(1'b1, hdr[i], s);
        cyc(w, 1'b1, s);
        cyc(w, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            cyc(w, wd[i], s);
            rd[i] = s;
        end
        cyc(1'b0, 1'b1, s);
    endtask
endmodule // pxc_host_model
